/* File: rtl/arw_ctrl.v */
// Converter control: result, window compare, events, flags and sleep handling
`timescale 1ns/10ps
`include "arw_consts.vh"
module arw_ctrl #(
    parameter DLY_W = `ARW_DLY_W
) (
    // Clock, reset, enable
    input  wire                   clk,
    input  wire                   rst_b,
    input  wire                   clk_en,
    // Configuration
    input  wire                   converter_enable,
    input  wire                   free_run,
    input  wire                   run_in_standby,
    input  wire [2:0]             accumulation_count_sel,
    input  wire [1:0]             reference_sel,
    input  wire [4:0]             input_channel_sel,
    input  wire                   sample_cap_sel,
    input  wire [DLY_W-1:0]       initial_delay_sel,
    input  wire [2:0]             window_compare_mode_sel,
    input  wire [`ARW_RES_W-1:0]  window_low_threshold,
    input  wire [`ARW_RES_W-1:0]  window_high_threshold,
    input  wire                   event_start_enable,
    input  wire [1:0]             interrupt_enable_reg,
    // Software commands
    input  wire                   start_cmd,
    input  wire                   result_read,
    input  wire [1:0]             flag_clear,
    // Sleep state
    input  wire [1:0]             sleep_mode,
    // Event trigger pin
    input  wire                   start_event,
    // Analog core
    input  wire                   sample_done,
    input  wire [`ARW_CODE_W-1:0] sample_code,
    // Outputs to analog front end
    output reg                    sample_req,
    output reg                    temp_sensor_on,
    output reg                    use_internal_ref,
    output reg                    reduced_cap,
    output reg                    periph_clk_req,
    // Status
    output reg                    start_conversion_bit,
    output reg [`ARW_RES_W-1:0]   conversion_result,
    output reg                    result_invalid,
    output reg [1:0]              interrupt_flag_reg,
    output reg                    irq_result_ready,
    output reg                    irq_window,
    output reg                    result_ready_event
);
    reg [1:0]             state;
    reg [1:0]             next_state;
    reg [DLY_W-1:0]       dly_cnt;
    reg [`ARW_CNT_W-1:0]  smp_cnt;
    reg [`ARW_RES_W-1:0]  acc;
    reg                   first_done;
    reg                   halted;
    reg                   ev_s1;
    reg                   ev_s2;
    reg                   ev_d;
    reg                   done_s1;
    reg                   done_s2;
    reg                   done_d;
    wire                  win_match;
    wire [`ARW_RES_W-1:0] acc_sum;
    wire [`ARW_RES_W-1:0] code_ext;
    wire                  ev_rise;
    wire                  done_rise;
    wire                  standby;
    wire                  pdown;
    wire                  active;
    wire                  last_sample;
    wire [`ARW_CNT_W-1:0] smp_target;
    wire                  sw_start;
    wire                  finish;
    reg  [1:0]            next_flags;

    assign standby   = (sleep_mode == `ARW_SLP_STANDBY);
    assign pdown     = (sleep_mode == `ARW_SLP_PDOWN);
    // Converter stops in standby without run-in-standby
    assign active    = converter_enable && !pdown && (!standby || run_in_standby);
    assign ev_rise   = ev_s2 && !ev_d;
    assign done_rise = done_s2 && !done_d;
    // Software start is ignored while asleep; only events or free-run go on
    assign sw_start  = start_cmd && !standby;
    // Reserved accumulation code acts as no accumulation
    assign smp_target = (accumulation_count_sel > `ARW_ACC_MAX) ? {`ARW_CNT_W{1'b0}} :
                        ((({{(`ARW_CNT_W-1){1'b0}}, 1'b1}) << accumulation_count_sel)
                         - {{(`ARW_CNT_W-1){1'b0}}, 1'b1});
    assign last_sample = (smp_cnt == smp_target);
    assign code_ext  = {{(`ARW_RES_W-`ARW_CODE_W){1'b0}}, sample_code};
    assign acc_sum   = (smp_cnt == {`ARW_CNT_W{1'b0}}) ? code_ext : acc + code_ext;
    assign finish    = (state == `ARW_ST_CONV) && active && done_rise && last_sample;

    arw_window_cmp #(
        .W        (`ARW_RES_W)
    ) u_cmp (
        .result   (acc_sum),
        .low_thr  (window_low_threshold),
        .high_thr (window_high_threshold),
        .mode     (window_compare_mode_sel),
        .match    (win_match)
    );

    // Event pin and sample-done inputs are asynchronous; two stages before use
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_s1   <= 1'b0;
            ev_s2   <= 1'b0;
            ev_d    <= 1'b0;
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_d  <= 1'b0;
        end else if (clk_en) begin
            ev_s1   <= start_event;
            ev_s2   <= ev_s1;
            ev_d    <= ev_s2;
            done_s1 <= sample_done;
            done_s2 <= done_s1;
            done_d  <= done_s2;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            `ARW_ST_IDLE: begin
                if (active && (sw_start || (event_start_enable && ev_rise))) begin
                    if (!first_done && initial_delay_sel != {DLY_W{1'b0}})
                        next_state = `ARW_ST_DELAY;
                    else
                        next_state = `ARW_ST_CONV;
                end
            end
            `ARW_ST_DELAY: begin
                if (active && dly_cnt == {DLY_W{1'b0}})
                    next_state = `ARW_ST_CONV;
            end
            `ARW_ST_CONV: begin
                if (finish)
                    next_state = `ARW_ST_FINISH;
            end
            `ARW_ST_FINISH: begin
                // Free-run chains straight into the next conversion
                if (free_run && active)
                    next_state = `ARW_ST_CONV;
                else
                    next_state = `ARW_ST_IDLE;
            end
            default: next_state = `ARW_ST_IDLE;
        endcase
        if (!converter_enable)
            next_state = `ARW_ST_IDLE;
    end

    // Flag update: hardware set beats software clear
    always @* begin
        next_flags = interrupt_flag_reg;
        if (flag_clear[0] || result_read)
            next_flags[0] = 1'b0;
        if (flag_clear[1])
            next_flags[1] = 1'b0;
        if (finish)
            next_flags[0] = 1'b1;
        if (finish && win_match)
            next_flags[1] = 1'b1;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state                <= `ARW_ST_IDLE;
            dly_cnt              <= {DLY_W{1'b0}};
            smp_cnt              <= {`ARW_CNT_W{1'b0}};
            acc                  <= {`ARW_RES_W{1'b0}};
            first_done           <= 1'b0;
            halted               <= 1'b0;
            sample_req           <= 1'b0;
            temp_sensor_on       <= 1'b0;
            use_internal_ref     <= 1'b0;
            reduced_cap          <= 1'b0;
            periph_clk_req       <= 1'b0;
            start_conversion_bit <= 1'b0;
            conversion_result    <= {`ARW_RES_W{1'b0}};
            result_invalid       <= 1'b0;
            interrupt_flag_reg   <= 2'h0;
            irq_result_ready     <= 1'b0;
            irq_window           <= 1'b0;
            result_ready_event   <= 1'b0;
        end else if (clk_en) begin
            state              <= next_state;
            interrupt_flag_reg <= next_flags;
            temp_sensor_on     <= converter_enable &&
                                  (input_channel_sel == `ARW_TEMP_CHAN);
            use_internal_ref   <= (reference_sel == `ARW_REF_INTERNAL);
            reduced_cap        <= sample_cap_sel;
            irq_result_ready   <= next_flags[0] && interrupt_enable_reg[0];
            irq_window         <= next_flags[1] && interrupt_enable_reg[1];
            result_ready_event <= finish && converter_enable;
            // Clock requested only while a conversion is pending
            periph_clk_req     <= (next_state != `ARW_ST_IDLE);
            sample_req         <= (next_state == `ARW_ST_CONV) && active;
            if (!converter_enable)
                first_done <= 1'b0;
            if (state == `ARW_ST_IDLE && next_state != `ARW_ST_IDLE) begin
                start_conversion_bit <= 1'b1;
                dly_cnt              <= initial_delay_sel;
                smp_cnt              <= {`ARW_CNT_W{1'b0}};
                halted               <= 1'b0;
            end
            if (state == `ARW_ST_DELAY && active && dly_cnt != {DLY_W{1'b0}})
                dly_cnt <= dly_cnt - {{(DLY_W-1){1'b0}}, 1'b1};
            // Halt keeps progress; mark result corrupt
            if (state == `ARW_ST_CONV && pdown)
                halted <= 1'b1;
            if (state == `ARW_ST_CONV && active && done_rise) begin
                acc <= acc_sum;
                if (last_sample)
                    smp_cnt <= {`ARW_CNT_W{1'b0}};
                else
                    smp_cnt <= smp_cnt + {{(`ARW_CNT_W-1){1'b0}}, 1'b1};
            end
            if (finish) begin
                conversion_result <= acc_sum;
                result_invalid    <= halted;
                halted            <= 1'b0;
                first_done        <= 1'b1;
                if (!free_run)
                    start_conversion_bit <= 1'b0;
            end
            if (!converter_enable)
                start_conversion_bit <= 1'b0;
        end
    end
endmodule // arw_ctrl

/* File: rtl/arw_consts.vh */
// Constants for the converter result, window and sleep control block
`ifndef ARW_CONSTS_VH
`define ARW_CONSTS_VH
`define ARW_RES_W        16
`define ARW_CODE_W       10
`define ARW_CODE_MAX     10'h3FF
`define ARW_WIN_OFF      3'h0
`define ARW_WIN_BELOW    3'h1
`define ARW_WIN_ABOVE    3'h2
`define ARW_WIN_INSIDE   3'h3
`define ARW_WIN_OUTSIDE  3'h4
`define ARW_ACC_NONE     3'h0
`define ARW_ACC_MAX      3'h6
`define ARW_REF_INTERNAL 2'h0
`define ARW_TEMP_CHAN    5'h1E
`define ARW_DLY_W        8
`define ARW_CNT_W        7
`define ARW_ST_IDLE      2'h0
`define ARW_ST_DELAY     2'h1
`define ARW_ST_CONV      2'h2
`define ARW_ST_FINISH    2'h3
`define ARW_SLP_ACTIVE   2'h0
`define ARW_SLP_STANDBY  2'h1
`define ARW_SLP_PDOWN    2'h2
`endif

/* File: rtl/arw_window_cmp.v */
// Window comparator: evaluates one result against the thresholds
`timescale 1ns/10ps
`include "arw_consts.vh"
module arw_window_cmp #(
    parameter W = 16
) (
    // Operands
    input  wire [W-1:0] result,
    input  wire [W-1:0] low_thr,
    input  wire [W-1:0] high_thr,
    input  wire [2:0]   mode,
    // Outcome
    output reg          match
);
    always @* begin
        case (mode)
            `ARW_WIN_BELOW:   match = (result < low_thr);
            `ARW_WIN_ABOVE:   match = (result > high_thr);
            `ARW_WIN_INSIDE:  match = (result > low_thr) && (result < high_thr);
            `ARW_WIN_OUTSIDE: match = (result < low_thr) || (result > high_thr);
            default:          match = 1'b0;
        endcase
    end
endmodule // arw_window_cmp

/* File: testbench/arw_ctrl_sva.sv */
// Checker for the converter control block ports
`timescale 1ns/10ps
module arw_ctrl_sva (
    // Clock and reset
    input wire       clk,
    input wire       rst_b,
    input wire       clk_en,
    // Watched signals
    input wire       free_run,
    input wire [1:0] reference_sel,
    input wire [1:0] interrupt_enable_reg,
    input wire       result_read,
    input wire       start_conversion_bit,
    input wire       use_internal_ref,
    input wire [1:0] interrupt_flag_reg,
    input wire       irq_result_ready,
    input wire       irq_window,
    input wire       result_ready_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    evt_one_cycle_a: assert property (result_ready_event |=> !result_ready_event)
        else $error("ready event wider than one cycle");
    rdy_irq_on_a: assert property ((clk_en && interrupt_flag_reg[0] && interrupt_enable_reg[0])[*2]
        |-> irq_result_ready) else $error("ready request missing");
    win_irq_on_a: assert property ((clk_en && interrupt_flag_reg[1] && interrupt_enable_reg[1])[*2]
        |-> irq_window) else $error("window request missing");
    rdy_irq_off_a: assert property ((!(interrupt_flag_reg[0] && interrupt_enable_reg[0]))[*2]
        |-> !irq_result_ready) else $error("ready request without flag");
    evt_sets_flag_a: assert property (result_ready_event |-> interrupt_flag_reg[0])
        else $error("ready event without flag");
    start_clear_a: assert property (result_ready_event && !free_run |-> !start_conversion_bit)
        else $error("start bit left set at completion");
    int_ref_a: assert property ((clk_en && reference_sel == 2'h0 && !start_conversion_bit)[*2]
        |-> use_internal_ref) else $error("internal reference not used");
    read_clear_a: assert property (clk_en && result_read && !result_ready_event
        ##1 !result_ready_event |-> !interrupt_flag_reg[0]) else $error("read left flag set");
endmodule // arw_ctrl_sva

bind arw_ctrl arw_ctrl_sva u_arw_ctrl_sva (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .free_run(free_run), .reference_sel(reference_sel), .interrupt_enable_reg(interrupt_enable_reg),
    .result_read(result_read), .start_conversion_bit(start_conversion_bit),
    .use_internal_ref(use_internal_ref), .interrupt_flag_reg(interrupt_flag_reg),
    .irq_result_ready(irq_result_ready), .irq_window(irq_window),
    .result_ready_event(result_ready_event));

/* File: testbench/arw_analog_model.sv */
// Analog core model answering sample requests
`timescale 1ns/10ps
module arw_analog_model (
    // Clock and bench control
    input  wire       clk,
    input  wire       slow,
    input  wire [9:0] code,
    // Block side
    input  wire       sample_req,
    output reg        sample_done,
    output reg  [9:0] sample_code
);
    initial begin
        sample_done = 1'b0;
        sample_code = 10'h155;
        forever begin
            @(posedge clk);
            if (sample_req === 1'b1) begin
                repeat (slow ? 20 : 2) @(posedge clk);
                #1 sample_code = code;
                sample_done = 1'b1;
                repeat (3) @(posedge clk);
                #1 sample_done = 1'b0;
                repeat (2) @(posedge clk);
                // Code only valid around the done edge
                #1 sample_code = ~code;
                repeat (3) @(posedge clk);
            end
        end
    end
endmodule // arw_analog_model

/* File: testbench/testbench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "arw_consts.vh"
module testbench;
    logic clk = 0, rst_b = 0, clk_en = 1, converter_enable = 1, free_run = 0, slow = 0;
    logic run_in_standby = 0, sample_cap_sel = 0, event_start_enable = 0, start_cmd = 0;
    logic result_read = 0, start_event = 0, sample_done, sample_req, temp_sensor_on, exp_win;
    logic use_internal_ref, reduced_cap, periph_clk_req, start_conversion_bit, result_invalid;
    logic irq_result_ready, irq_window, result_ready_event;
    logic [2:0] accumulation_count_sel = 0, window_compare_mode_sel = 0;
    logic [1:0] reference_sel = 0, interrupt_enable_reg = 0, flag_clear = 0, interrupt_flag_reg;
    logic [1:0] sleep_mode = `ARW_SLP_ACTIVE;
    logic [4:0] input_channel_sel = 0;
    logic [7:0] initial_delay_sel = 0;
    logic [9:0] code = 0, sample_code;
    logic [15:0] window_low_threshold = 0, window_high_threshold = 0, conversion_result, exp_res;
    integer n_mismatch = 0, comparisons = 0, k, i;

    always #5 clk = ~clk;

    arw_ctrl u_arw_ctrl (.clk, .rst_b, .clk_en, .converter_enable, .free_run, .run_in_standby,
        .accumulation_count_sel, .reference_sel, .input_channel_sel, .sample_cap_sel,
        .initial_delay_sel, .window_compare_mode_sel, .window_low_threshold,
        .window_high_threshold, .event_start_enable, .interrupt_enable_reg, .start_cmd,
        .result_read, .flag_clear, .sleep_mode, .start_event, .sample_done, .sample_code,
        .sample_req, .temp_sensor_on, .use_internal_ref, .reduced_cap, .periph_clk_req,
        .start_conversion_bit, .conversion_result, .result_invalid, .interrupt_flag_reg,
        .irq_result_ready, .irq_window, .result_ready_event);
    arw_analog_model u_arw_analog_model (.clk, .slow, .code, .sample_req, .sample_done,
        .sample_code);

    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("errors %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Start by command (0), by event pin (1) or none (2), then wait for completion
    task conv(input integer how);
        if (how == 1) start_event = 1;
        if (how == 0) start_cmd = 1;
        cyc(1);
        start_cmd = 0;
        for (i = 0; i < 3000 && result_ready_event !== 1'b1; i++) cyc(1);
        start_event = 0;
        if (i == 3000) n_mismatch++;
    endtask
    function logic win(input logic [2:0] m, input logic [15:0] r, lo, hi);
        case (m)
            `ARW_WIN_BELOW: win = r < lo;
            `ARW_WIN_ABOVE: win = r > hi;
            `ARW_WIN_INSIDE: win = r > lo && r < hi;
            `ARW_WIN_OUTSIDE: win = r < lo || r > hi;
            default: win = 1'b0;
        endcase
    endfunction

    initial begin
        // Worst case is seven slow and eight fast 64-sample conversions plus the sleep cases
        #600000;
        n_mismatch++;
        test_done;
    end

    initial begin
        k = $urandom(32'h8d93e5b1);
        cyc(12);
        rst_b = 1;
        cyc(2);
        for (k = 0; k < 16; k++) begin
            code = $urandom % 1024;
            slow = k[0];
            event_start_enable = k[1];
            input_channel_sel = k[2] ? `ARW_TEMP_CHAN : 5'($urandom % 30);
            // Temperature readings use internal reference and reduced capacitance
            reference_sel = k[2] ? `ARW_REF_INTERNAL : 2'($urandom % 4);
            sample_cap_sel = k[3] | k[2];
            interrupt_enable_reg = $urandom % 4;
            window_compare_mode_sel = k[2:0];
            accumulation_count_sel = (k == 6 || k == 7) ? k[2:0] : $urandom % 8;
            exp_res = code * (accumulation_count_sel % 7 == 0 ? 16'h1 : 16'h1 << accumulation_count_sel);
            window_low_threshold = (k == 3) ? exp_res : $urandom % (2 * exp_res + 2);
            window_high_threshold = window_low_threshold + $urandom % (2 * exp_res + 2);
            exp_win = win(window_compare_mode_sel, exp_res, window_low_threshold, window_high_threshold);
            flag_clear = 2'h3;
            cyc(1);
            flag_clear = 2'h0;
            chk(interrupt_flag_reg, 2'h0, "flags cleared");
            cyc(2);
            conv(k[1]);
            chk(conversion_result, exp_res, "result");
            chk(interrupt_flag_reg, {exp_win, 1'b1}, "flags");
            chk(start_conversion_bit, 1'b0, "start bit");
            chk(temp_sensor_on, input_channel_sel == `ARW_TEMP_CHAN, "sensor");
            chk(use_internal_ref, reference_sel == 2'h0, "internal ref");
            chk(reduced_cap, sample_cap_sel, "reduced cap");
            cyc(1);
            chk(irq_window, interrupt_enable_reg[1] & exp_win, "window irq");
            chk(irq_result_ready, interrupt_enable_reg[0], "ready irq");
        end
        result_read = 1;
        cyc(1);
        result_read = 0;
        chk(interrupt_flag_reg[0], 1'b0, "read clear");
        // Event pin must be ignored when event start is off
        {slow, event_start_enable, accumulation_count_sel, start_event} = 6'b100001;
        cyc(8);
        start_event = 0;
        chk(start_conversion_bit, 1'b0, "no event start");
        event_start_enable = 1;
        sleep_mode = `ARW_SLP_STANDBY;
        start_event = 1;
        cyc(8);
        start_event = 0;
        chk(sample_req, 1'b0, "standby idle");
        run_in_standby = 1;
        start_cmd = 1;
        cyc(1);
        start_cmd = 0;
        cyc(8);
        chk(start_conversion_bit, 1'b0, "standby command");
        conv(1);
        chk(interrupt_flag_reg[0], 1'b1, "standby done");
        cyc(3);
        chk(periph_clk_req, 1'b0, "clock released");
        sleep_mode = `ARW_SLP_ACTIVE;
        flag_clear = 2'h3;
        cyc(1);
        flag_clear = 2'h0;
        start_cmd = 1;
        cyc(1);
        start_cmd = 0;
        cyc(3);
        sleep_mode = `ARW_SLP_PDOWN;
        cyc(40);
        chk(interrupt_flag_reg[0], 1'b0, "halted");
        sleep_mode = `ARW_SLP_ACTIVE;
        conv(2);
        chk(result_invalid, 1'b1, "invalid result");
        converter_enable = 0;
        initial_delay_sel = 8'h28;
        cyc(3);
        converter_enable = 1;
        start_cmd = 1;
        for (i = 0; i < 200 && sample_req !== 1'b1; i++) cyc(1);
        start_cmd = 0;
        chk(i >= 40, 1'b1, "initial delay");
        conv(2);
        test_done;
    end
endmodule // testbench
